// ### unsigned_subtract_multiply_unit.sv
// lane subtract and multiply datapath with an AXI4-Lite register slave
`timescale 1ns/1ps
`include "msu_regs.svh"
module unsigned_subtract_multiply_unit (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	msu_pkg::core_s coreReg;
	msu_pkg::core_s coreNext;
	msu_pkg::mem_req_s memReq;
	logic [31:0] memRdata;
	logic [31:0] halfDiff;
	logic [31:0] byteDiff;
	logic [63:0] prodU;
	logic [63:0] prodS;
	logic [63:0] wideTwo;
	logic [63:0] wideAcc;
	logic [31:0] mul32;
	logic awFire;
	logic wFire;
	logic arFire;
	logic commit;
	logic isIdle;
	logic isLong;
	logic [7:0] cAddr;
	logic [7:0] rAddrW;
	logic [31:0] cData;
	logic [3:0] cStrb;
	logic [31:0] ctrlImg;
	logic [31:0] ctrlNew;
	logic [31:0] flagNew;
	logic [31:0] statImg;

	operand_store u_store (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.req(memReq),
		.rdata(memRdata)
	);

	// ---------------------------------------------
	// bus handshakes
	// ---------------------------------------------
	assign isIdle = coreReg.st == msu_pkg::ST_IDLE;
	assign awready = !coreReg.awHeld && !coreReg.bvalid;
	assign wready = !coreReg.wHeld && !coreReg.bvalid;
	// operand store has one read port, so bus reads wait while the datapath runs
	assign arready = isIdle && !coreReg.rPend && !coreReg.rvalid;
	assign awFire = awvalid && awready;
	assign wFire = wvalid && wready;
	assign arFire = arvalid && arready;
	assign cAddr = coreReg.awHeld ? coreReg.awAddr : {awaddr[7:2], 2'b00};
	assign cData = coreReg.wHeld ? coreReg.wData : wdata;
	assign cStrb = coreReg.wHeld ? coreReg.wStrb : wstrb;
	assign commit = (coreReg.awHeld || awvalid) && (coreReg.wHeld || wvalid)
		&& !coreReg.bvalid;
	assign rAddrW = {coreReg.rAddr[7:2], 2'b00};
	assign bvalid = coreReg.bvalid;
	assign bresp = coreReg.bresp;
	assign rvalid = coreReg.rvalid;
	assign rdata = coreReg.rdata;
	assign rresp = coreReg.rresp;

	// ---------------------------------------------
	// register images
	// ---------------------------------------------
	always_comb
	begin
		ctrlImg = `MSU_WORD_RST;
		ctrlImg[`MSU_F_OP +: 4] = coreReg.ctrl.op;
		ctrlImg[`MSU_F_DLO +: 4] = coreReg.ctrl.dLo;
		ctrlImg[`MSU_F_SRC1 +: 4] = coreReg.ctrl.src1;
		ctrlImg[`MSU_F_SRC2 +: 4] = coreReg.ctrl.src2;
		ctrlImg[`MSU_F_XREG +: 4] = coreReg.ctrl.xReg;
		ctrlImg[`MSU_F_OMIT] = coreReg.ctrl.omitDest;
		ctrlImg[`MSU_F_SETF] = coreReg.ctrl.setFlags;
		statImg = `MSU_WORD_RST;
		statImg[`MSU_STAT_BUSY] = !isIdle;
		statImg[`MSU_STAT_DONE] = coreReg.done;
		statImg[`MSU_STAT_ERR] = coreReg.err;
	end

	// ---------------------------------------------
	// lanes and products
	// ---------------------------------------------
	for (genvar i = 0; i < 4; i++)
	begin : g_byte
		assign ctrlNew[8*i +: 8] = cStrb[i] ? cData[8*i +: 8] : ctrlImg[8*i +: 8];
		assign flagNew[8*i +: 8] = cStrb[i] ? cData[8*i +: 8] :
			((i == 0) ? {4'h0, coreReg.flags} : 8'h00);
		// each lane wraps on its own
		assign byteDiff[8*i +: 8] = coreReg.opA[8*i +: 8] - coreReg.opB[8*i +: 8];
	end

	for (genvar h = 0; h < 2; h++)
	begin : g_half
		assign halfDiff[16*h +: 16] = coreReg.opA[16*h +: 16] - coreReg.opB[16*h +: 16];
	end

	// zero-extended operands give the unsigned product
	assign prodU = {32'h00000000, coreReg.opA} * {32'h00000000, coreReg.opB};
	// sign-extended operands give the signed product
	assign prodS = {{32{coreReg.opA[31]}}, coreReg.opA} * {{32{coreReg.opB[31]}}, coreReg.opB};
	// low word is the same for signed and unsigned operands
	assign mul32 = prodU[31:0];
	// prior upper and lower words as separate unsigned terms
	assign wideTwo = prodU + {32'h00000000, coreReg.opX} + {32'h00000000, memRdata};
	// prior pair taken as one 64-bit value
	assign wideAcc = prodU + {coreReg.opX, memRdata};
	assign isLong = coreReg.ctrl.op inside {msu_pkg::OP_U_WIDE, msu_pkg::OP_U_WIDE_TWO,
		msu_pkg::OP_U_WIDE_ACC, msu_pkg::OP_S_WIDE};

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb
	begin
		coreNext = coreReg;
		memReq = '0;
		if (coreReg.bvalid && bready)
		begin
			coreNext.bvalid = 1'b0;
		end
		if (coreReg.rvalid && rready)
		begin
			coreNext.rvalid = 1'b0;
		end
		if (commit)
		begin
			coreNext.awHeld = 1'b0;
			coreNext.wHeld = 1'b0;
			coreNext.bvalid = 1'b1;
			coreNext.bresp = `MSU_RESP_OKAY;
			if ((cAddr & `MSU_RF_MASK) == `MSU_RF_BASE)
			begin
				coreNext.bresp = isIdle ? `MSU_RESP_OKAY : `MSU_RESP_SLVERR;
				memReq.we = isIdle;
				memReq.waddr = cAddr[5:2];
				memReq.wdata = cData;
				memReq.wstrb = cStrb;
			end
			else if (cAddr == `MSU_CTRL_OFS)
			begin
				coreNext.bresp = isIdle ? `MSU_RESP_OKAY : `MSU_RESP_SLVERR;
				if (isIdle)
				begin
					coreNext.ctrl.op = msu_pkg::op_e'(ctrlNew[`MSU_F_OP +: 4]);
					coreNext.ctrl.dLo = ctrlNew[`MSU_F_DLO +: 4];
					coreNext.ctrl.src1 = ctrlNew[`MSU_F_SRC1 +: 4];
					coreNext.ctrl.src2 = ctrlNew[`MSU_F_SRC2 +: 4];
					coreNext.ctrl.xReg = ctrlNew[`MSU_F_XREG +: 4];
					coreNext.ctrl.omitDest = ctrlNew[`MSU_F_OMIT];
					coreNext.ctrl.setFlags = ctrlNew[`MSU_F_SETF];
					if (ctrlNew[`MSU_F_START] && cStrb[3])
					begin
						coreNext.done = 1'b0;
						coreNext.err = 1'b0;
						if (ctrlNew[`MSU_F_OP +: 4] <= msu_pkg::OP_S_WIDE)
						begin
							coreNext.st = msu_pkg::ST_SRC1;
						end
						else
						begin
							coreNext.err = 1'b1;
							coreNext.done = 1'b1;
						end
					end
				end
			end
			else if (cAddr == `MSU_FLAG_OFS)
			begin
				coreNext.bresp = isIdle ? `MSU_RESP_OKAY : `MSU_RESP_SLVERR;
				if (isIdle)
				begin
					coreNext.flags = flagNew[3:0];
				end
			end
			else if (cAddr != `MSU_STAT_OFS && cAddr != `MSU_RLO_OFS && cAddr != `MSU_RHI_OFS)
			begin
				coreNext.bresp = `MSU_RESP_DECERR;
			end
		end
		else
		begin
			if (awFire)
			begin
				coreNext.awHeld = 1'b1;
				coreNext.awAddr = {awaddr[7:2], 2'b00};
			end
			if (wFire)
			begin
				coreNext.wHeld = 1'b1;
				coreNext.wData = wdata;
				coreNext.wStrb = wstrb;
			end
		end
		if (arFire)
		begin
			coreNext.rPend = 1'b1;
			coreNext.rAddr = araddr;
			memReq.raddr = araddr[5:2];
		end
		if (coreReg.rPend)
		begin
			coreNext.rPend = 1'b0;
			coreNext.rvalid = 1'b1;
			coreNext.rresp = `MSU_RESP_OKAY;
			if ((rAddrW & `MSU_RF_MASK) == `MSU_RF_BASE)
				coreNext.rdata = memRdata;
			else if (rAddrW == `MSU_CTRL_OFS)
				coreNext.rdata = ctrlImg;
			else if (rAddrW == `MSU_STAT_OFS)
				coreNext.rdata = statImg;
			else if (rAddrW == `MSU_FLAG_OFS)
				coreNext.rdata = {28'h0000000, coreReg.flags};
			else if (rAddrW == `MSU_RLO_OFS)
				coreNext.rdata = coreReg.resLo;
			else if (rAddrW == `MSU_RHI_OFS)
				coreNext.rdata = coreReg.resHi;
			else
			begin
				coreNext.rdata = `MSU_WORD_RST;
				coreNext.rresp = `MSU_RESP_DECERR;
			end
		end
		case (coreReg.st)
			msu_pkg::ST_IDLE:
			begin
			end
			msu_pkg::ST_SRC1:
			begin
				memReq.raddr = coreReg.ctrl.src1;
				coreNext.st = msu_pkg::ST_SRC2;
			end
			msu_pkg::ST_SRC2:
			begin
				memReq.raddr = coreReg.ctrl.src2;
				coreNext.opA = memRdata;
				coreNext.st = msu_pkg::ST_RX;
			end
			msu_pkg::ST_RX:
			begin
				memReq.raddr = coreReg.ctrl.xReg;
				coreNext.opB = memRdata;
				coreNext.st = msu_pkg::ST_RL;
			end
			msu_pkg::ST_RL:
			begin
				memReq.raddr = coreReg.ctrl.dLo;
				coreNext.opX = memRdata;
				coreNext.st = msu_pkg::ST_CALC;
			end
			msu_pkg::ST_CALC:
			begin
				coreNext.st = msu_pkg::ST_WL;
				coreNext.resHi = `MSU_WORD_RST;
				// lane modes never touch the flags
				case (coreReg.ctrl.op)
					msu_pkg::OP_HALF_DIFF: coreNext.resLo = halfDiff;
					msu_pkg::OP_BYTE_DIFF: coreNext.resLo = byteDiff;
					// low word of the product only
					msu_pkg::OP_MUL: coreNext.resLo = mul32;
					msu_pkg::OP_PLUS_ADDEND: coreNext.resLo = mul32 + coreReg.opX;
					// product taken from addend, borrow dropped
					msu_pkg::OP_ADDEND_MINUS: coreNext.resLo = coreReg.opX - mul32;
					msu_pkg::OP_U_WIDE: {coreNext.resHi, coreNext.resLo} = prodU;
					msu_pkg::OP_U_WIDE_TWO: {coreNext.resHi, coreNext.resLo} = wideTwo;
					msu_pkg::OP_U_WIDE_ACC: {coreNext.resHi, coreNext.resLo} = wideAcc;
					msu_pkg::OP_S_WIDE: {coreNext.resHi, coreNext.resLo} = prodS;
					default: coreNext.resLo = `MSU_WORD_RST;
				endcase
				// negative and zero only, carry and overflow kept
				if (coreReg.ctrl.op == msu_pkg::OP_MUL && coreReg.ctrl.setFlags)
				begin
					coreNext.flags[`MSU_FLAG_N] = mul32[31];
					coreNext.flags[`MSU_FLAG_Z] = mul32 == `MSU_WORD_RST;
				end
			end
			msu_pkg::ST_WL:
			begin
				memReq.we = 1'b1;
				memReq.wstrb = 4'hf;
				memReq.wdata = coreReg.resLo;
				// omitted destination falls back to the first source for single-word results; wide results always go to dLo
				memReq.waddr = (!isLong && coreReg.ctrl.omitDest) ? coreReg.ctrl.src1 :
					coreReg.ctrl.dLo;
				coreNext.st = isLong ? msu_pkg::ST_WH : msu_pkg::ST_IDLE;
				coreNext.done = !isLong;
			end
			msu_pkg::ST_WH:
			begin
				// upper word to the upper destination
				memReq.we = 1'b1;
				memReq.wstrb = 4'hf;
				memReq.wdata = coreReg.resHi;
				memReq.waddr = coreReg.ctrl.xReg;
				coreNext.st = msu_pkg::ST_IDLE;
				coreNext.done = 1'b1;
			end
			default: coreNext.st = msu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			coreReg <= '0;
			coreReg.st <= msu_pkg::ST_IDLE;
			coreReg.flags <= `MSU_FLAGS_RST;
		end
		else
		begin
			coreReg <= coreNext;
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence wlOf(msu_pkg::op_e o);
		coreReg.st == msu_pkg::ST_WL && coreReg.ctrl.op == o;
	endsequence
	sequence calcLane;
		coreReg.st == msu_pkg::ST_CALC && coreReg.ctrl.op inside
			{msu_pkg::OP_HALF_DIFF, msu_pkg::OP_BYTE_DIFF};
	endsequence

	a_half_lanes: assert property (wlOf(msu_pkg::OP_HALF_DIFF) |->
		memReq.wdata == {coreReg.opA[31:16] - coreReg.opB[31:16],
		coreReg.opA[15:0] - coreReg.opB[15:0]})
		else $error("halfword lane result wrong");
	a_byte_wrap: assert property (wlOf(msu_pkg::OP_BYTE_DIFF) |->
		memReq.wdata[15:8] == coreReg.opA[15:8] - coreReg.opB[15:8])
		else $error("byte lane not independent");
	a_lane_flags: assert property (calcLane |=> $stable(coreReg.flags))
		else $error("lane subtract changed flags");
	a_mul_low: assert property (wlOf(msu_pkg::OP_MUL) |->
		memReq.wdata == 32'(coreReg.opA * coreReg.opB))
		else $error("multiply low word wrong");
	a_mls_diff: assert property (wlOf(msu_pkg::OP_ADDEND_MINUS) |->
		memReq.wdata + 32'(coreReg.opA * coreReg.opB) == coreReg.opX)
		else $error("addend minus product wrong");
	a_mul_flags: assert property ((coreReg.st == msu_pkg::ST_CALC
		&& coreReg.ctrl.op == msu_pkg::OP_MUL && coreReg.ctrl.setFlags) |=>
		coreReg.flags[1:0] == $past(coreReg.flags[1:0])
		&& coreReg.flags[`MSU_FLAG_Z] == (coreReg.resLo == 32'h00000000))
		else $error("flag update wrong");
	a_omit_dest: assert property ((coreReg.st == msu_pkg::ST_WL && !isLong
		&& coreReg.ctrl.omitDest) |-> memReq.waddr == coreReg.ctrl.src1)
		else $error("result not sent to first source");
	a_wide_pair: assert property (wlOf(msu_pkg::OP_U_WIDE) |->
		memReq.wdata == prodU[31:0] ##1 (memReq.we
		&& memReq.waddr == coreReg.ctrl.xReg && memReq.wdata == prodU[63:32]))
		else $error("wide product split wrong");
	a_start_run: assert property ((commit && isIdle && cAddr == `MSU_CTRL_OFS
		&& cStrb[3] && ctrlNew[`MSU_F_START] && ctrlNew[`MSU_F_OP +: 4] <= 4'h8) |=>
		coreReg.st == msu_pkg::ST_SRC1 ##5 coreReg.st == msu_pkg::ST_WL)
		else $error("operation sequence broken");

endmodule : unsigned_subtract_multiply_unit

// ### msu_regs.svh
// register offsets, field positions and reset values of the subtract/multiply unit
`ifndef MSU_REGS_SVH
`define MSU_REGS_SVH
// byte offsets on the register bus
`define MSU_CTRL_OFS 8'h00
`define MSU_STAT_OFS 8'h04
`define MSU_FLAG_OFS 8'h08
`define MSU_RLO_OFS 8'h0c
`define MSU_RHI_OFS 8'h10
`define MSU_RF_BASE 8'h40
`define MSU_RF_MASK 8'hc0
// control word fields
`define MSU_F_OP 0
`define MSU_F_DLO 4
`define MSU_F_SRC1 8
`define MSU_F_SRC2 12
`define MSU_F_XREG 16
`define MSU_F_OMIT 20
`define MSU_F_SETF 21
`define MSU_F_START 31
// status and flag bits
`define MSU_STAT_BUSY 0
`define MSU_STAT_DONE 1
`define MSU_STAT_ERR 2
`define MSU_FLAG_N 3
`define MSU_FLAG_Z 2
`define MSU_FLAG_C 1
`define MSU_FLAG_V 0
// bus answers and reset values
`define MSU_RESP_OKAY 2'h0
`define MSU_RESP_SLVERR 2'h2
`define MSU_RESP_DECERR 2'h3
`define MSU_FLAGS_RST 4'h0
`define MSU_WORD_RST 32'h00000000
`endif

// ### msu_pkg.sv
// types shared by the subtract/multiply unit and its operand store
package msu_pkg;

	typedef enum logic [3:0] {
		OP_HALF_DIFF = 4'h0,
		OP_BYTE_DIFF = 4'h1,
		OP_MUL = 4'h2,
		OP_PLUS_ADDEND = 4'h3,
		OP_ADDEND_MINUS = 4'h4,
		OP_U_WIDE = 4'h5,
		OP_U_WIDE_TWO = 4'h6,
		OP_U_WIDE_ACC = 4'h7,
		OP_S_WIDE = 4'h8
	} op_e;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_SRC1 = 8'h02,
		ST_SRC2 = 8'h04,
		ST_RX = 8'h08,
		ST_RL = 8'h10,
		ST_CALC = 8'h20,
		ST_WL = 8'h40,
		ST_WH = 8'h80
	} exec_state_e;

	typedef struct packed {
		logic we;
		logic [3:0] wstrb;
		logic [3:0] waddr;
		logic [31:0] wdata;
		logic [3:0] raddr;
	} mem_req_s;

	typedef struct packed {
		logic [15:0][31:0] word;
		logic [31:0] rdata;
	} mem_state_s;

	typedef struct packed {
		op_e op;
		logic [3:0] dLo;
		logic [3:0] src1;
		logic [3:0] src2;
		logic [3:0] xReg;
		logic omitDest;
		logic setFlags;
	} ctrl_s;

	typedef struct packed {
		exec_state_e st;
		ctrl_s ctrl;
		logic [31:0] opA;
		logic [31:0] opB;
		logic [31:0] opX;
		logic [31:0] resLo;
		logic [31:0] resHi;
		logic [3:0] flags;
		logic done;
		logic err;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rPend;
		logic [7:0] rAddr;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} core_s;

endpackage : msu_pkg

// ### operand_store.sv
// sixteen-word operand store with byte-lane writes and a registered read port
`timescale 1ns/1ps
module operand_store (
	input wire logic sys_clk,
	input wire logic rst_n,
	input msu_pkg::mem_req_s req,
	output logic [31:0] rdata
);

	msu_pkg::mem_state_s memReg;
	msu_pkg::mem_state_s memNext;
	logic [31:0] merged;

	// ---------------------------------------------
	// byte lanes
	// ---------------------------------------------
	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		assign merged[8*i +: 8] = req.wstrb[i] ? req.wdata[8*i +: 8] :
			memReg.word[req.waddr][8*i +: 8];
	end

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	// read before write: a same-cycle write shows up one read later
	always_comb
	begin
		memNext = memReg;
		memNext.rdata = memReg.word[req.raddr];
		if (req.we)
		begin
			memNext.word[req.waddr] = merged;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memReg <= '0;
		end
		else
		begin
			memReg <= memNext;
		end
	end

	assign rdata = memReg.rdata;

endmodule : operand_store

// ### lite_master.sv
// AXI4-Lite master standing in for the core that drives the unit
`timescale 1ns/1ps
module lite_master (
	input wire logic sys_clk,
	output logic [7:0] awaddr,
	output logic [2:0] awprot,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic [2:0] arprot,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial
	begin
		{awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arprot, arvalid, rready} = '0;
	end
	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// handshakes sampled at the falling edge: inputs only move after rising edges,
	// so this sees what the next rising edge sees without a race
	// no cycle limit here: only the bench watchdog ends a hung wait
	task automatic write_word(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tw;
		logic tb;
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'bxx;
		do
		begin
			@(negedge sys_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb)
				r = bresp;
			@(posedge sys_clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tb);
		bready <= 1'b0;
	endtask : write_word
	task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic tr;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		d = 32'hxxxxxxxx;
		r = 2'bxx;
		do
		begin
			@(negedge sys_clk);
			ta = arvalid && arready;
			tr = rvalid;
			if (tr)
			begin
				d = rdata;
				r = rresp;
			end
			@(posedge sys_clk);
			if (ta)
				arvalid <= 1'b0;
		end
		while (!tr);
		rready <= 1'b0;
	endtask : read_word
endmodule : lite_master

// ### tb_top.sv
// self-checking bench for the lane subtract and multiply unit
`timescale 1ns/1ps
`include "msu_regs.svh"
`define CHK(nm, e, g) \
	begin \
		testsRun++; \
		if ((g) !== (e)) \
		begin \
			nFail++; \
			$display("[FAIL] %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb_top;
	logic sysClk;
	logic rstN;
	logic [7:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] resp;
	logic [31:0] word;
	int nFail = 0;
	int testsRun = 0;
	initial sysClk = 1'b0;
	always #5 sysClk = ~sysClk;
	lite_master lite_master_i (.sys_clk(sysClk), .awaddr, .awprot, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	unsigned_subtract_multiply_unit unsigned_subtract_multiply_unit_i (.sys_clk(sysClk),
		.rst_n(rstN), .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		lite_master_i.write_word(a, d, resp);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		lite_master_i.read_word(a, word, resp);
	endtask : rd
	task automatic ld(input int i, input logic [31:0] d);
		wr(`MSU_RF_BASE + 8'(4 * i), d);
	endtask : ld
	task automatic get(input int i);
		rd(`MSU_RF_BASE + 8'(4 * i));
	endtask : get
	task automatic wait_done();
		int n;
		n = 0;
		do
		begin
			rd(`MSU_STAT_OFS);
			n++;
		end
		while (word[`MSU_STAT_DONE] !== 1'b1 && n < 40);
		`CHK("done seen", 1'b1, word[`MSU_STAT_DONE])
	endtask : wait_done
	// registers 13 to 15 unused, standing for stack and program counter
	task automatic run_op(input logic [3:0] op, dl, s1, s2, x, input logic om, sf);
		wr(`MSU_CTRL_OFS, {1'b1, 9'h0, sf, om, x, s2, s1, dl, op});
		wait_done();
	endtask : run_op
	task automatic chk_pair(input string nm, input logic [63:0] e);
		get(3);
		`CHK(nm, e[31:0], word)
		get(4);
		`CHK(nm, e[63:32], word)
	endtask : chk_pair
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_lanes();
		logic [31:0] a, b;
		a = 32'h0005_8000;
		b = 32'h0006_0001;
		ld(1, a);
		ld(2, b);
		wr(`MSU_FLAG_OFS, 32'h0000_000a);
		run_op(msu_pkg::OP_HALF_DIFF, 4'h3, 4'h1, 4'h2, 4'h0, 1'b0, 1'b0);
		get(3);
		`CHK("half diff", {a[31:16] - b[31:16], a[15:0] - b[15:0]}, word)
		a = 32'h0010_ff01;
		b = 32'h0101_0002;
		ld(1, a);
		ld(2, b);
		run_op(msu_pkg::OP_BYTE_DIFF, 4'h7, 4'h1, 4'h2, 4'h0, 1'b1, 1'b0);
		get(1);
		`CHK("byte diff", {a[31:24] - b[31:24], a[23:16] - b[23:16], a[15:8] - b[15:8],
			a[7:0] - b[7:0]}, word)
		get(7);
		`CHK("omitted dest", 32'h0, word)
		rd(`MSU_FLAG_OFS);
		`CHK("lane flags", 32'h0000_000a, word)
		$display("lanes test done");
	endtask : t_lanes
	task automatic t_mul32();
		logic [31:0] a, b, x;
		logic [63:0] p;
		a = 32'hffff_fffe;
		b = 32'h0000_0003;
		x = 32'h0000_0010;
		p = {32'h0, a} * {32'h0, b};
		ld(1, a);
		ld(2, b);
		ld(3, x);
		run_op(msu_pkg::OP_MUL, 4'h4, 4'h1, 4'h2, 4'h0, 1'b0, 1'b0);
		get(4);
		`CHK("mul", p[31:0], word)
		`CHK("mul signed view", 32'($signed(a) * $signed(b)), word)
		run_op(msu_pkg::OP_PLUS_ADDEND, 4'h5, 4'h1, 4'h2, 4'h3, 1'b0, 1'b0);
		get(5);
		`CHK("plus addend", x + p[31:0], word)
		run_op(msu_pkg::OP_ADDEND_MINUS, 4'h6, 4'h1, 4'h2, 4'h3, 1'b0, 1'b0);
		get(6);
		`CHK("addend minus", x - p[31:0], word)
		wr(`MSU_FLAG_OFS, 32'h0000_0003);
		// low registers only, destination equal to second source
		run_op(msu_pkg::OP_MUL, 4'h2, 4'h1, 4'h2, 4'h0, 1'b0, 1'b1);
		rd(`MSU_FLAG_OFS);
		`CHK("flags negative", 32'h0000_000b, word)
		ld(7, 32'h0);
		run_op(msu_pkg::OP_MUL, 4'h2, 4'h7, 4'h2, 4'h0, 1'b0, 1'b1);
		rd(`MSU_FLAG_OFS);
		`CHK("flags zero", 32'h0000_0007, word)
		$display("mul32 test done");
	endtask : t_mul32
	task automatic t_wide();
		logic [31:0] a, b;
		logic [63:0] p, e;
		a = 32'hffff_ffff;
		b = a;
		p = {32'h0, a} * {32'h0, b};
		ld(1, a);
		ld(2, b);
		// upper and lower destinations kept apart
		run_op(msu_pkg::OP_U_WIDE, 4'h3, 4'h1, 4'h2, 4'h4, 1'b0, 1'b0);
		chk_pair("unsigned wide", p);
		rd(`MSU_RHI_OFS);
		`CHK("result upper", p[63:32], word)
		ld(3, 32'hffff_ffff);
		ld(4, 32'hffff_ffff);
		e = p + 64'h0000_0000_ffff_ffff + 64'h0000_0000_ffff_ffff;
		run_op(msu_pkg::OP_U_WIDE_TWO, 4'h3, 4'h1, 4'h2, 4'h4, 1'b0, 1'b0);
		chk_pair("two addends", e);
		ld(3, 32'h0000_0001);
		ld(4, 32'h0000_0002);
		e = p + 64'h0000_0002_0000_0001;
		run_op(msu_pkg::OP_U_WIDE_ACC, 4'h3, 4'h1, 4'h2, 4'h4, 1'b0, 1'b0);
		chk_pair("wide acc", e);
		b = 32'h0000_0002;
		ld(2, b);
		e = {{32{a[31]}}, a} * {{32{b[31]}}, b};
		run_op(msu_pkg::OP_S_WIDE, 4'h3, 4'h1, 4'h2, 4'h4, 1'b0, 1'b0);
		chk_pair("signed wide", e);
		$display("wide test done");
	endtask : t_wide
	task automatic t_bus();
		rd(8'h20);
		`CHK("unmapped rresp", `MSU_RESP_DECERR, resp)
		`CHK("unmapped rdata", 32'h0, word)
		wr(8'h24, 32'h0000_0001);
		`CHK("unmapped bresp", `MSU_RESP_DECERR, resp)
		run_op(4'h9, 4'h3, 4'h1, 4'h2, 4'h4, 1'b0, 1'b0);
		`CHK("illegal op err", 1'b1, word[`MSU_STAT_ERR])
		ld(9, 32'h5a5a_5a5a);
		wr(`MSU_CTRL_OFS, {1'b1, 9'h0, 2'b00, 4'h4, 4'h2, 4'h1, 4'h3, 4'h5});
		ld(9, 32'h0000_0001);
		`CHK("busy bresp", `MSU_RESP_SLVERR, resp)
		wait_done();
		get(9);
		`CHK("busy word kept", 32'h5a5a_5a5a, word)
		rd(`MSU_CTRL_OFS);
		`CHK("ctrl readback", 32'h0004_2135, word)
		$display("bus test done");
	endtask : t_bus
	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial
	begin
		rstN = 1'b0;
		repeat (3) @(posedge sysClk);
		rstN <= 1'b1;
		t_lanes();
		t_mul32();
		t_wide();
		t_bus();
		summarize();
	end
	// the whole run needs a few hundred cycles; this leaves ample room
	initial
	begin
		repeat (20000) @(posedge sysClk);
		nFail++;
		$display("[FAIL] watchdog expected finish seen timeout");
		summarize();
	end
endmodule : tb_top
